//--- rcc_regs.vh
// register map, field positions and constants of the reset cause capture block
// Contract
// RQ1: watchdog expiry asserts reset, clock kept
// RQ2: expiry in sleep or idle only wakes
// RQ3: watchdog expiry sets status bit 4
// RQ4: lower hard trap during higher resets
// RQ5: trap conflict sets status bit 15
// RQ6: shadow compare mismatch resets device
// RQ7: mismatch sets bit 9, optional source
// RQ8: upper byte 3f opcode resets device
// RQ9: illegal conditions set status bit 14
// RQ10: resets clear working regs except stack
// RQ11: only word load marks register initialized
// RQ12: flow change into protected segment resets
// RQ13: power-on or brown-out aborts self-programming
// RQ14: other resets wait for self-programming end
// RQ15: power-save, clear, por, bor clear watchdog flag
// RQ16: software sets or clears any flag
// RQ17: software reads then clears flags
// RQ18: oscillator and calendar reset only at power-on
// RQ19: control bits placed, bits 12,10 zero
// RQ20: power-on value is 0003
// RQ21: pin reset sets status bit 7
// RQ22: reset instruction sets status bit 6
// RQ23: power-on sets status bit 0
// RQ24: brown-out sets status bit 1
// RQ25: por/bor clear flags, pin only by por
// RQ26: reset line follows any active source
`ifndef RCC_REGS_VH
`define RCC_REGS_VH
// ************************************************************
// register offsets
// ************************************************************
`define RCC_ADDR_STATUS   4'h0
`define RCC_ADDR_WREG     4'h4
`define RCC_ADDR_CFG      4'h8
// ************************************************************
// status fields
// ************************************************************
`define RCC_B_POR    0
`define RCC_B_BOR    1
`define RCC_B_IDLE   2
`define RCC_B_SLEEP  3
`define RCC_B_WDT    4
`define RCC_B_SOFT_WATCHDOG_ENABLE 5
`define RCC_B_SW     6
`define RCC_B_PIN    7
`define RCC_B_REGULATOR_STANDBY  8
`define RCC_B_CM     9
`define RCC_B_REGULATOR_STANDBY_FLASH 11
`define RCC_B_SOFT_BROWNOUT_ENABLE 13
`define RCC_B_ILL    14
`define RCC_B_TRAP   15
`define RCC_STATUS_POR    16'h0003
`define RCC_STATUS_WMASK  16'hebff
`define RCC_ILLEGAL_OPC   8'h3f
`define RCC_HARD_LVL_LO   4'hd
`define RCC_HARD_LVL_HI   4'hf
`define RCC_NUM_WREG      16
`define RCC_OSC_RESET     16'h0000
`endif

//--- rcc_reset_cause.v
// reset cause capture: source combining, status register, working register tracking
`timescale 1ns/1ps
`include "rcc_regs.vh"
module rcc_reset_cause #(
  parameter CM_PRESENT = 1
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // analog and pin reset sources (asynchronous)
  input  wire        por_event,
  input  wire        bor_event,
  input  wire        master_clear_pin_n,
  // core events (same clock)
  input  wire        reset_instruction,
  input  wire        watchdog_expiry,
  input  wire        power_save_instruction,
  input  wire        power_save_idle,
  input  wire        watchdog_clear_instruction,
  input  wire        cpu_sleeping,
  input  wire        cpu_idle,
  input  wire        trap_in_service,
  input  wire [3:0]  trap_service_level,
  input  wire        trap_new,
  input  wire [3:0]  trap_new_level,
  input  wire [15:0] pin_select_regs,
  input  wire [15:0] pin_select_shadow,
  input  wire        opcode_exec,
  input  wire [7:0]  opcode_upper,
  input  wire        wreg_word_load,
  input  wire        wreg_byte_load,
  input  wire [3:0]  wreg_index,
  input  wire        wreg_addr_use,
  input  wire [3:0]  wreg_addr_index,
  input  wire        program_flow_change,
  input  wire        vector_flow_change,
  input  wire        flow_target_restricted,
  input  wire        self_programming_operation,
  input  wire [15:0] osc_cfg_wdata,
  input  wire        osc_cfg_we,
  // outputs to the core
  output reg         system_reset_line,
  output reg         wake_request,
  output reg         self_prog_abort,
  output reg  [15:0] wreg_init_flags,
  output reg  [15:0] osc_cfg_q,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ************************************************************
  // synchronisers for asynchronous sources
  // ************************************************************
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 3'h1;
      sync2_reg <= 3'h1;
    end else begin
      sync1_reg <= {~master_clear_pin_n, bor_event, por_event};
      sync2_reg <= sync1_reg;
    end
  end
  wire por_s = sync2_reg[0];
  wire bor_s = sync2_reg[1];
  wire pin_s = sync2_reg[2];
  reg  por_d_reg;
  reg  bor_d_reg;

  // ************************************************************
  // status register state
  // ************************************************************
  reg [15:0] status_reg;
  reg [15:0] status_next;
  wire       soft_brownout_enable = status_reg[`RCC_B_SOFT_BROWNOUT_ENABLE];
  wire       bor_act = bor_s & soft_brownout_enable;
  wire       cold_edge = (por_s & ~por_d_reg) | (bor_act & ~bor_d_reg);
  wire       asleep = cpu_sleeping | cpu_idle;

  // ************************************************************
  // source detection
  // ************************************************************
  wire wdt_reset = watchdog_expiry & ~asleep;                             // RQ1 RQ2
  wire trap_hard = (trap_new_level >= `RCC_HARD_LVL_LO) &&
                   (trap_new_level <= `RCC_HARD_LVL_HI);
  wire trap_conf = trap_new & trap_hard & trap_in_service &
                   (trap_new_level < trap_service_level);                 // RQ4
  wire cm_reset  = (CM_PRESENT != 0) && (pin_select_regs != pin_select_shadow); // RQ6 RQ7
  wire opc_reset = opcode_exec && (opcode_upper == `RCC_ILLEGAL_OPC);      // RQ8
  wire uwr_reset = wreg_addr_use & ~wreg_init_flags[wreg_addr_index];     // RQ10
  wire sec_reset = (program_flow_change | vector_flow_change) &
                   flow_target_restricted;                                // RQ12
  wire ill_reset = opc_reset | uwr_reset | sec_reset;
  wire warm_req  = pin_s | reset_instruction | wdt_reset | trap_conf |
                   cm_reset | ill_reset;

  // warm requests held off while self-programming runs
  reg  warm_pend_reg;
  wire warm_go = (warm_req | warm_pend_reg) & ~self_programming_operation; // RQ14
  wire cold = por_s | bor_act;

  // ************************************************************
  // bus write decode
  // ************************************************************
  reg  [3:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_have_reg;
  reg         w_have_reg;
  wire        wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire        wr_stat = wr_fire && (awaddr_reg == `RCC_ADDR_STATUS);
  wire [15:0] wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}} & `RCC_STATUS_WMASK;

  always @* begin
    status_next = status_reg;
    if (wr_stat)
      status_next = (status_reg & ~wmask) | (wdata_reg[15:0] & wmask);    // RQ16
    if (power_save_instruction | watchdog_clear_instruction)
      status_next[`RCC_B_WDT] = 1'b0;                                      // RQ15
    // sleep and idle flags set here or by a status write; a cold reset or a status write clears them
    if (power_save_instruction) begin
      if (power_save_idle)
        status_next[`RCC_B_IDLE] = 1'b1;
      else
        status_next[`RCC_B_SLEEP] = 1'b1;
    end
    // causes are recorded when requested, so a deferred reset keeps its cause
    if (warm_req) begin
      if (pin_s) status_next[`RCC_B_PIN] = 1'b1;                           // RQ21
      if (reset_instruction) status_next[`RCC_B_SW] = 1'b1;               // RQ22
      if (wdt_reset | watchdog_expiry) status_next[`RCC_B_WDT] = 1'b1;    // RQ3
      if (trap_conf) status_next[`RCC_B_TRAP] = 1'b1;                      // RQ5
      if (cm_reset) status_next[`RCC_B_CM] = 1'b1;                         // RQ7
      if (ill_reset) status_next[`RCC_B_ILL] = 1'b1;                       // RQ9
    end
    if (watchdog_expiry) status_next[`RCC_B_WDT] = 1'b1;                  // RQ3
    if (cold_edge) begin
      status_next[`RCC_B_TRAP] = 1'b0;                                     // RQ25
      status_next[`RCC_B_ILL] = 1'b0;
      status_next[`RCC_B_CM] = 1'b0;
      status_next[`RCC_B_SW] = 1'b0;
      status_next[`RCC_B_WDT] = 1'b0;                                      // RQ15
      status_next[`RCC_B_SLEEP] = 1'b0;
      status_next[`RCC_B_IDLE] = 1'b0;
      status_next[`RCC_B_BOR] = 1'b1;                                      // RQ24
      if (por_s) begin
        status_next = `RCC_STATUS_POR;                                     // RQ20 RQ23 RQ25
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg    <= `RCC_STATUS_POR;                                    // RQ20
      por_d_reg     <= 1'b0;
      bor_d_reg     <= 1'b0;
      warm_pend_reg <= 1'b0;
    end else begin
      status_reg    <= status_next;                                        // RQ17
      por_d_reg     <= por_s;
      bor_d_reg     <= bor_act;
      warm_pend_reg <= self_programming_operation & (warm_req | warm_pend_reg); // RQ14
    end
  end

  // ************************************************************
  // reset line, wake, abort, power-on-only registers
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_line <= 1'b1;
      wake_request      <= 1'b0;
      self_prog_abort   <= 1'b0;
      osc_cfg_q         <= `RCC_OSC_RESET;
    end else begin
      system_reset_line <= cold | warm_go;                                 // RQ1 RQ26
      wake_request      <= watchdog_expiry & asleep;                       // RQ2
      self_prog_abort   <= cold & self_programming_operation;              // RQ13
      if (por_s)
        osc_cfg_q <= `RCC_OSC_RESET;                                       // RQ18
      else if (osc_cfg_we)
        osc_cfg_q <= osc_cfg_wdata;
    end
  end

  // ************************************************************
  // working register initialisation tracking
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      wreg_init_flags <= 16'h8000;
    end else if (cold | warm_go) begin
      wreg_init_flags <= 16'h8000;                                         // RQ10
    end else if (wreg_word_load) begin
      wreg_init_flags[wreg_index] <= 1'b1;                                 // RQ11
    end else if (wreg_byte_load && (wreg_index != 4'hf)) begin
      wreg_init_flags[wreg_index] <= 1'b0;                                 // RQ11
    end
  end

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 4'h0;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == `RCC_ADDR_STATUS) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `RCC_ADDR_STATUS: s_axi_rdata <= {16'h0000, status_reg};         // RQ19
          `RCC_ADDR_WREG:   s_axi_rdata <= {16'h0000, wreg_init_flags};
          `RCC_ADDR_CFG:    s_axi_rdata <= {16'h0000, osc_cfg_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rcc_reset_cause

//--- rcc_reset_cause_properties.sv
// checker of reset source timing and working register tracking
`timescale 1ns/1ps
module rcc_reset_cause_properties (
  // clock and reset
  input wire aclk, aresetn,
  // core events and working register flags
  input wire watchdog_expiry, cpu_sleeping, cpu_idle, trap_in_service, trap_new,
  input wire opcode_exec, wreg_byte_load, wreg_word_load, wreg_addr_use,
  input wire program_flow_change, vector_flow_change, flow_target_restricted,
  input wire self_programming_operation, reset_instruction,
  input wire [3:0] trap_service_level, trap_new_level, wreg_index, wreg_addr_index,
  input wire [7:0] opcode_upper,
  input wire [15:0] pin_select_regs, pin_select_shadow, wreg_init_flags,
  // block outputs
  input wire system_reset_line, wake_request, s_axi_rvalid
);
  // ****
  // core warm sources reach the reset line one cycle later unless self-programming runs
  // ****
  wire sp = self_programming_operation;
  wire rl = system_reset_line;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_WDT_RESET: assert property (
    watchdog_expiry && !cpu_sleeping && !cpu_idle && !sp |=> rl) else $error("wdt no reset");
  AST_WDT_WAKE: assert property (
    watchdog_expiry && (cpu_sleeping || cpu_idle) |=> wake_request) else $error("no wake");
  AST_TRAP_CONFLICT: assert property (
    trap_new && trap_in_service && trap_new_level >= 4'hd
    && trap_new_level < trap_service_level && !sp |=> rl) else $error("trap no reset");
  AST_SHADOW: assert property (
    pin_select_regs != pin_select_shadow && !sp |=> rl) else $error("mismatch no reset");
  AST_OPCODE: assert property (
    opcode_exec && opcode_upper == 8'h3f && !sp |=> rl) else $error("opcode no reset");
  AST_UNINIT_USE: assert property (
    wreg_addr_use && !wreg_init_flags[wreg_addr_index] && !sp |=> rl)
    else $error("uninit use no reset");
  AST_BYTE_LOAD: assert property (
    wreg_byte_load && !wreg_word_load && wreg_index != 4'hf
    |=> !wreg_init_flags[$past(wreg_index)]) else $error("byte load initialized");
  AST_FLOW: assert property (
    (program_flow_change || vector_flow_change) && flow_target_restricted && !sp |=> rl)
    else $error("flow no reset");
  AST_DEFER: assert property (
    sp && reset_instruction && !rl ##1 sp |-> !rl) else $error("reset not deferred");
  cover property (watchdog_expiry && cpu_sleeping ##1 wake_request);
  cover property (rl ##1 !rl);
  cover property (s_axi_rvalid);
endmodule // rcc_reset_cause_properties
bind rcc_reset_cause rcc_reset_cause_properties rcc_reset_cause_properties_inst (.*);

//--- rcc_core_model.sv
// core side model: watchdog, trap, shadow, instruction and flow events
`timescale 1ns/1ps
module rcc_core_model (
  // clock
  input wire aclk,
  // events toward the reset block
  output reg reset_instruction, watchdog_expiry, power_save_instruction, power_save_idle,
  output reg watchdog_clear_instruction, cpu_sleeping, cpu_idle, trap_in_service, trap_new,
  output reg opcode_exec, wreg_word_load, wreg_byte_load, wreg_addr_use, program_flow_change,
  output reg vector_flow_change, flow_target_restricted, self_programming_operation,
  output reg [3:0] trap_service_level, trap_new_level, wreg_index, wreg_addr_index,
  output reg [7:0] opcode_upper,
  output reg [15:0] pin_select_regs, pin_select_shadow
);
  // ****
  // one event per call, pulses last one cycle
  // ****
  task quiet;
    begin
      {reset_instruction, watchdog_expiry, power_save_instruction, watchdog_clear_instruction,
       cpu_sleeping, trap_in_service, trap_new, opcode_exec, wreg_word_load, wreg_byte_load,
       wreg_addr_use, program_flow_change, vector_flow_change, flow_target_restricted} <= 0;
      pin_select_regs <= pin_select_shadow;
    end
  endtask
  initial begin
    {power_save_idle, cpu_idle, self_programming_operation} = 0;
    {trap_service_level, trap_new_level, wreg_index, wreg_addr_index, opcode_upper} = 0;
    pin_select_shadow = 16'h0000;
    quiet;
  end
  task fire(input integer k, input [3:0] a);
    begin
      @(posedge aclk);
      case (k)
        0: watchdog_expiry <= 1;
        1: {trap_in_service, trap_service_level, trap_new, trap_new_level} <= 10'h3fd;
        2: pin_select_regs <= ~pin_select_shadow;
        3: {opcode_exec, opcode_upper} <= 9'h13f;
        4: {wreg_addr_use, wreg_addr_index} <= {1'b1, a};
        5: {program_flow_change, flow_target_restricted} <= 2'h3;
        6: {vector_flow_change, flow_target_restricted} <= 2'h3;
        7: reset_instruction <= 1;
        8: {power_save_instruction, power_save_idle} <= {1'b1, a[0]};
        9: watchdog_clear_instruction <= 1;
        10: {wreg_word_load, wreg_index} <= {1'b1, a};
        11: {wreg_byte_load, wreg_index} <= {1'b1, a};
        12: {cpu_sleeping, watchdog_expiry} <= 2'h3;
        default: self_programming_operation <= a[0];
      endcase
      @(posedge aclk);
      quiet;
    end
  endtask
endmodule // rcc_core_model

//--- rcc_reset_cause_test.sv
// testbench of the reset cause capture block
`timescale 1ns/1ps
`define CK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module rcc_reset_cause_test;
  logic aclk = 0, aresetn = 0, por_event = 0, bor_event = 0, master_clear_pin_n = 1;
  logic osc_cfg_we = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [15:0] osc_cfg_wdata = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, rdat, rnd;
  logic [1:0] resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire system_reset_line, wake_request, self_prog_abort;
  wire reset_instruction, watchdog_expiry, power_save_instruction, power_save_idle;
  wire watchdog_clear_instruction, cpu_sleeping, cpu_idle, trap_in_service, trap_new;
  wire opcode_exec, wreg_word_load, wreg_byte_load, wreg_addr_use, program_flow_change;
  wire vector_flow_change, flow_target_restricted, self_programming_operation;
  wire [3:0] trap_service_level, trap_new_level, wreg_index, wreg_addr_index;
  wire [7:0] opcode_upper;
  wire [15:0] pin_select_regs, pin_select_shadow, wreg_init_flags, osc_cfg_q;
  integer err_total = 0, num_checks = 0, seed, m, k, n;
  int bt [0:7] = '{4, 15, 9, 14, 14, 14, 14, 6};
  rcc_reset_cause rcc_reset_cause_inst (.*);
  rcc_core_model core_inst (.*);
  initial forever #20 aclk = ~aclk;
  // ****
  // bus and wait tasks
  // ****
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task xfer(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      n = 0;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
      if (n >= 40) begin err_total++; close_out; end
      resp = w ? s_axi_bresp : s_axi_rresp;
      rdat = s_axi_rdata;
      {s_axi_bready, s_axi_rready} <= 0;
    end
  endtask
  task rs;
    begin
      xfer(0, 4'h0, 0);
      `CK("status", {16'h0, m[15:0]}, rdat)
    end
  endtask
  task wt(input v);
    begin
      for (n = 0; n < 30 && system_reset_line !== v; n++) @(posedge aclk);
      if (n >= 30) begin `CK("rst", v, system_reset_line) close_out; end
    end
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    seed = 26042;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    m = 3;
    rs;
    `CK("winit", 16'h8000, wreg_init_flags)
    xfer(0, 4'hc, 0);
    `CK("rresp", 2'h2, resp)
    xfer(1, 4'h4, 0);
    `CK("bresp", 2'h2, resp)
    rnd = $random(seed);
    xfer(1, 4'h0, rnd);
    m = rnd & 16'hebff;
    rs;
    `CK("rst", 1'b0, system_reset_line)
    master_clear_pin_n <= 0;
    wt(1);
    master_clear_pin_n <= 1;
    wt(0);
    m = m | 16'h80;
    rs;
    for (k = 0; k < 8; k++) begin
      core_inst.fire(k, 0);
      wt(1);
      wt(0);
      m = m | (1 << bt[k]);
      rs;
      `CK("winit", 16'h8000, wreg_init_flags)
      xfer(1, 0, 0);
      m = 0;
    end
    core_inst.fire(12, 0);
    #1 `CK("rst", 1'b0, system_reset_line)
    `CK("wake", 1'b1, wake_request)
    m = 16'h10;
    rs;
    core_inst.fire(8, 1);
    m = 16'h04;
    rs;
    core_inst.fire(12, 0);
    core_inst.fire(9, 0);
    core_inst.fire(8, 0);
    m = 16'h0c;
    rs;
    core_inst.fire(10, 3);
    core_inst.fire(11, 5);
    core_inst.fire(11, 5);
    #1 `CK("winit", 16'h8008, wreg_init_flags)
    core_inst.fire(11, 3);
    #1 `CK("winit", 16'h8000, wreg_init_flags)
    core_inst.fire(13, 1);
    core_inst.fire(7, 0);
    repeat (4) @(posedge aclk);
    #1 `CK("rst", 1'b0, system_reset_line)
    core_inst.fire(13, 0);
    wt(1);
    wt(0);
    m = 16'h4c;
    rs;
    xfer(1, 0, 16'ha080);
    {osc_cfg_wdata, osc_cfg_we} <= {rnd[31:16], 1'b1};
    @(posedge aclk);
    osc_cfg_we <= 0;
    core_inst.fire(13, 1);
    bor_event <= 1;
    for (n = 0; n < 10 && self_prog_abort !== 1'b1; n++) @(posedge aclk);
    `CK("abort", 1'b1, self_prog_abort)
    wt(1);
    bor_event <= 0;
    core_inst.fire(13, 0);
    wt(0);
    m = 16'h2082;
    rs;
    `CK("osc", rnd[31:16], osc_cfg_q)
    por_event <= 1;
    wt(1);
    por_event <= 0;
    wt(0);
    m = 3;
    rs;
    `CK("osc", 16'h0, osc_cfg_q)
    close_out;
  end
endmodule // rcc_reset_cause_test
